// ### rtl/host_bus_register_port.sv
// pin-side front end of the host microprocessor register port
// assumes the register core answers REG_RDATA combinationally from REG_ADDR
// and that host pins change slowly compared to the 100 ns clock
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) fourteen bit address picks the register
// (RULE_02) top address bit picks test map
// (RULE_03) chip reset acts at once, no clock
// (RULE_04) latch enable low holds captured address
// (RULE_05) latch enable high passes address through
// (RULE_06) host latches address before reusing lines
// (RULE_07) enabled active source pulls interrupt low
// (RULE_08) acknowledging access releases the interrupt line
// (RULE_09) interrupt pin only drives low or floats
// (RULE_10) bus style pin picks strobe scheme
// (RULE_11) separate strobes: read drives data bus
// (RULE_12) separate strobes: write on strobe rise
// (RULE_13) strobe-select mode: write on strobe fall
// (RULE_14) data bus floats unless reading
module host_bus_register_port #(
    parameter int IRQ_N_SRC = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CHIP_RESET_N,
    input wire logic [13:0] ADDR,
    input wire logic ADDR_LATCH_EN,
    input wire logic BUS_STYLE_SELECT_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic IRQ_N_OUT,
    output logic IRQ_N_OE,
    output logic [12:0] REG_ADDR,
    output logic REG_TEST_MAP,
    output logic REG_WR,
    output logic [7:0] REG_WDATA,
    output logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic [IRQ_N_SRC-1:0] IRQ_SOURCE,
    input wire logic [IRQ_N_SRC-1:0] IRQ_ENABLE
);
    // synchronised pin bundle width: addr, ale, style, cs, rd, wr, data
    localparam int PIN_W = host_port_pkg::ADDR_W + 5 + host_port_pkg::DATA_W;

    // whole state of the port
    typedef struct packed {
        logic [13:0] addr_hold;          // captured address while latch closed
        logic [13:0] addr_cur;           // address of the current access
        logic strobe_prev;               // previous strobe level (write strobe pin, or read strobe pin in strobe-select mode)
        logic read_prev;                 // previous read condition
        logic [7:0] d_out;               // data bus drive value
        logic d_oe;                      // data bus drive enable
        logic wr;                        // write pulse to core
        logic [7:0] wdata;               // write data to core
        logic rd;                        // read start pulse to core
        logic [IRQ_N_SRC-1:0] pending;   // sticky interrupt bits
    } state_t;

    state_t st;
    state_t next_st;
    // reset image of the state
    state_t st_reset;

    // synchronised pins
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins;
    logic [13:0] a_s;
    logic ale_s;
    logic style_n_s;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [7:0] d_s;
    // decoded access conditions
    logic [13:0] addr_eff;
    logic read_cond;
    logic strobe_lvl;
    logic write_edge;
    logic read_start;
    logic ack_read;

    assign pins_raw = {ADDR, ADDR_LATCH_EN, BUS_STYLE_SELECT_N, CHIP_SELECT_N,
                       READ_STROBE_N, WRITE_STROBE_N, DATA_IN};

    // every host bus pin except the chip reset passes two flops before use
    pin_sync #(.WIDTH(PIN_W)) u_sync (
        .CLK(CLK),
        .ASYNC_IN(pins_raw),
        .RESET_VALUE('0),
        .SYNC_OUT(pins)
    );

    assign {a_s, ale_s, style_n_s, cs_n_s, rd_n_s, wr_n_s, d_s} = pins;

    always_comb begin
        st_reset = '0;
        st_reset.addr_hold = host_port_pkg::ADDR_RESET;
        st_reset.addr_cur = host_port_pkg::ADDR_RESET;
        st_reset.d_out = host_port_pkg::DATA_RESET;
        // idle level is high for the separate-style write strobe; the strobe-select strobe is active high
        st_reset.strobe_prev = 1'b1;
    end

    // address path and access decode
    always_comb begin
        // (RULE_05) transparent while enabled
        // (RULE_04) held copy while closed
        addr_eff = ale_s ? a_s : st.addr_hold;
        if (!style_n_s) begin
            // (RULE_10) strobe plus read/write select
            read_cond = !cs_n_s && wr_n_s && rd_n_s;
            // strobe is active high here, read on the read strobe pin
            strobe_lvl = rd_n_s;
            // (RULE_13) write on falling strobe with select low
            write_edge = st.strobe_prev && !strobe_lvl && !cs_n_s && !wr_n_s;
        end else begin
            // (RULE_10) separate read and write strobes
            // (RULE_11) read while strobe and select low
            read_cond = !cs_n_s && !rd_n_s;
            strobe_lvl = wr_n_s;
            // (RULE_12) write on rising strobe with select low
            write_edge = !st.strobe_prev && strobe_lvl && !cs_n_s;
        end
        read_start = read_cond && !st.read_prev;
        // (RULE_08) read of the acknowledge offset in normal map
        ack_read = read_start && !addr_eff[host_port_pkg::TEST_MAP_BIT]
                   && (addr_eff[12:0] == host_port_pkg::IRQ_ACK_OFFSET);
    end

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.strobe_prev = strobe_lvl;
        next_st.read_prev = read_cond;
        next_st.wr = 1'b0;
        next_st.rd = 1'b0;
        // (RULE_04) capture only while the latch is open
        if (ale_s) begin
            next_st.addr_hold = a_s;
        end
        // (RULE_01) address handed to the core per access
        if (read_cond || write_edge) begin
            next_st.addr_cur = addr_eff;
        end
        // write pulse with data sampled alongside the strobe
        if (write_edge) begin
            next_st.wr = 1'b1;
            next_st.wdata = d_s;
        end
        // read start pulse lets the core act on reads
        if (read_start) begin
            next_st.rd = 1'b1;
        end
        // (RULE_11) refresh drive value while reading
        // (RULE_14) release the bus when no read is active
        next_st.d_oe = read_cond;
        if (read_cond) begin
            next_st.d_out = REG_RDATA;
        end
        // (RULE_08) acknowledge clears, new source event wins
        if (ack_read) begin
            next_st.pending = '0;
        end
        // (RULE_07) enabled active sources set pending
        next_st.pending = next_st.pending | (IRQ_SOURCE & IRQ_ENABLE);
    end

    // state register; chip reset pin clears at once
    // hazard: the pin reset is asynchronous, so it only loads constants
    always_ff @(posedge CLK or negedge CHIP_RESET_N) begin
        if (!CHIP_RESET_N) begin
            // (RULE_03) immediate reset without clock
            st <= '{addr_hold: 14'h0000, addr_cur: 14'h0000, strobe_prev: 1'b1,
                    read_prev: 1'b0, d_out: 8'h00, d_oe: 1'b0, wr: 1'b0,
                    wdata: 8'h00, rd: 1'b0, pending: '0};
        end else if (RESET) begin
            st <= st_reset;
        end else begin
            st <= next_st;
        end
    end

    // (RULE_02) map select from the top address bit
    assign REG_TEST_MAP = st.addr_cur[host_port_pkg::TEST_MAP_BIT];
    // (RULE_01) lower bits select within the map
    assign REG_ADDR = st.addr_cur[12:0];
    assign REG_WR = st.wr;
    assign REG_WDATA = st.wdata;
    assign REG_RD = st.rd;
    assign DATA_OUT = st.d_out;
    assign DATA_OE = st.d_oe;
    // (RULE_09) open drain: output value fixed low
    assign IRQ_N_OUT = 1'b0;
    // (RULE_07) enable drive while anything pending
    assign IRQ_N_OE = |st.pending;
endmodule : host_bus_register_port

// ### rtl/host_port_pkg.sv
// shared constants for the parallel host register port
// assumes one 10 MHz system clock and asynchronous pins toward the host
package host_port_pkg;
    // address and data widths of the pin bus
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    // position of the map select bit in the address
    localparam int TEST_MAP_BIT = 13;
    // normal-map offset whose read acknowledges pending interrupts
    localparam logic [12:0] IRQ_ACK_OFFSET = 13'h0000;
    // reset value of the held address
    localparam logic [13:0] ADDR_RESET = 14'h0000;
    // reset value of the data output register
    localparam logic [7:0] DATA_RESET = 8'h00;
    // pin synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage : host_port_pkg

// ### rtl/pin_sync.sv
// two-flop synchroniser bank for host pins
// assumes inputs are asynchronous to CLK; first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    input wire logic [WIDTH-1:0] RESET_VALUE,
    output logic [WIDTH-1:0] SYNC_OUT
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta;
    // second stage, safe to use
    logic [WIDTH-1:0] stable;

    // no reset: reset would have to load a port value, so stages just flush
    always_ff @(posedge CLK) begin
        meta <= ASYNC_IN;
        stable <= meta;
    end

    // reset value port kept for width agreement; output is the second stage
    assign SYNC_OUT = stable;
endmodule : pin_sync

// ### sim/host_port_sva.sv
// checker for the host register port: timing of pulses, read drive and interrupt pin
// assumes host pins move slowly against CLK and are idle during reset
`timescale 1ns/1ps
module host_port_sva #(
    parameter int IRQ_N_SRC = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CHIP_RESET_N,
    input wire logic BUS_STYLE_SELECT_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic DATA_OE,
    input wire logic IRQ_N_OUT,
    input wire logic IRQ_N_OE,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [IRQ_N_SRC-1:0] IRQ_SOURCE,
    input wire logic [IRQ_N_SRC-1:0] IRQ_ENABLE
);
    // either reset silences every check
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET || !CHIP_RESET_N);
    property p_irq_pin; IRQ_N_OUT == 1'b0; endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq pin drives high");
    property p_irq_set; |(IRQ_SOURCE & IRQ_ENABLE) |=> IRQ_N_OE; endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not raised");
    property p_irq_quiet; !IRQ_N_OE && !(|(IRQ_SOURCE & IRQ_ENABLE)) |=> !IRQ_N_OE; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("spurious irq");
    property p_wr_once; REG_WR |=> !REG_WR; endproperty
    a_wr_once: assert property (p_wr_once) else $error("write pulse too long");
    property p_rd_once; REG_RD |=> !REG_RD; endproperty
    a_rd_once: assert property (p_rd_once) else $error("read pulse too long");
    property p_oe_start; $rose(DATA_OE) |-> REG_RD; endproperty
    a_oe_start: assert property (p_oe_start) else $error("drive without read");
    property p_sep_read; (BUS_STYLE_SELECT_N && !CHIP_SELECT_N && !READ_STROBE_N) [*4] |-> DATA_OE; endproperty
    a_sep_read: assert property (p_sep_read) else $error("read not driven");
    property p_idle_float; CHIP_SELECT_N [*4] |-> !DATA_OE; endproperty
    a_idle_float: assert property (p_idle_float) else $error("bus driven idle");
    property p_wr_cs; REG_WR |-> $past(CHIP_SELECT_N, 3) == 1'b0; endproperty
    a_wr_cs: assert property (p_wr_cs) else $error("write without select");
endmodule : host_port_sva
bind host_bus_register_port host_port_sva #(.IRQ_N_SRC(IRQ_N_SRC)) u_sva (.*);

// ### sim/reg_core_model.sv
// register core behind the port: eight bytes in each of the two maps
// assumes writes arrive as one-cycle pulses; read data is combinational
`timescale 1ns/1ps
module reg_core_model (
    input wire logic CLK,
    input wire logic [12:0] REG_ADDR,
    input wire logic REG_TEST_MAP,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA
);
    logic [7:0] mem [16]; // test map in the upper half
    assign REG_RDATA = mem[{REG_TEST_MAP, REG_ADDR[2:0]}];
    always @(posedge CLK) if (REG_WR) mem[{REG_TEST_MAP, REG_ADDR[2:0]}] <= REG_WDATA;
endmodule : reg_core_model

// ### sim/host_bus_register_port_tb.sv
// self-checking bench for the host register port, both strobe styles
// assumes the register core model above answers reads at once
`timescale 1ns/1ps
module host_bus_register_port_tb;
    logic CLK = 0, RESET = 1, CHIP_RESET_N = 1, ALE = 1, BSN = 1, CSN = 1, RSN = 1, WSN = 1;
    logic [13:0] ADDR = 14'h0000;
    logic [7:0] DIN = 8'h00, DOUT, RDATA, SRC = 8'h00, ENA = 8'h04, q;
    logic OE, IRQ_N_OUT, IRQ_N_OE, WR, RD, TMAP;
    logic [12:0] RADDR;
    logic [7:0] WDATA;
    int err_count = 0, samples_checked = 0;
    always #50 CLK = ~CLK;
    host_bus_register_port u_dut (.CLK(CLK), .RESET(RESET), .CHIP_RESET_N(CHIP_RESET_N),
        .ADDR(ADDR), .ADDR_LATCH_EN(ALE), .BUS_STYLE_SELECT_N(BSN), .CHIP_SELECT_N(CSN),
        .READ_STROBE_N(RSN), .WRITE_STROBE_N(WSN), .DATA_IN(DIN), .DATA_OUT(DOUT),
        .DATA_OE(OE), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE), .REG_ADDR(RADDR),
        .REG_TEST_MAP(TMAP), .REG_WR(WR), .REG_WDATA(WDATA), .REG_RD(RD),
        .REG_RDATA(RDATA), .IRQ_SOURCE(SRC), .IRQ_ENABLE(ENA));
    reg_core_model u_core (.CLK(CLK), .REG_ADDR(RADDR), .REG_TEST_MAP(TMAP), .REG_WR(WR),
        .REG_WDATA(WDATA), .REG_RDATA(RDATA));
    task w(input int n); repeat (n) @(posedge CLK); endtask : w
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one byte access; sep high = separate strobes, rnw held past the strobe end
    task acc(input logic sep, input logic rd, input logic [13:0] a, input logic [7:0] d);
        @(posedge CLK);
        BSN <= sep;
        // style settles with select high: strobe history of the old style must not look like an edge
        w(4);
        ADDR <= a; DIN <= d; CSN <= 1'b0; WSN <= rd;
        RSN <= sep ? !rd : 1'b1;
        w(5); #1;
        q = DOUT;
        chk(OE, rd);
        @(posedge CLK);
        RSN <= sep; WSN <= sep ? 1'b1 : rd;
        w(5);
        CSN <= 1'b1; WSN <= 1'b1;
        w(5); #1;
        chk(OE, 1'b0);
    endtask : acc
    // both maps, both styles, write then read back
    // latch held open: address passes straight through
    task t_map;
        acc(1'b1, 1'b0, 14'h0005, 8'ha5);
        acc(1'b0, 1'b0, 14'h2005, 8'h3c);
        acc(1'b1, 1'b1, 14'h0005, 8'h00);
        chk(q, 8'ha5);
        acc(1'b0, 1'b1, 14'h2005, 8'h00);
        chk(q, 8'h3c);
    endtask : t_map
    // latch closed: later address pins are ignored
    task t_latch;
        @(posedge CLK) ADDR <= 14'h0005;
        w(4);
        // address captured before the lines change
        ALE <= 1'b0;
        acc(1'b1, 1'b1, 14'h2006, 8'h00);
        chk(q, 8'ha5);
        ALE <= 1'b1;
    endtask : t_latch
    // masked source stays quiet, enabled one sticks until acknowledged
    task t_irq;
        SRC <= 8'h02; w(3); #1;
        chk(IRQ_N_OE, 1'b0);
        @(posedge CLK) SRC <= 8'h04;
        @(posedge CLK) SRC <= 8'h00;
        w(2); #1;
        chk(IRQ_N_OE, 1'b1);
        chk(IRQ_N_OUT, 1'b0);
        acc(1'b1, 1'b1, 14'h0000, 8'h00);
        chk(IRQ_N_OE, 1'b0);
        @(posedge CLK) SRC <= 8'h04;
        @(posedge CLK) SRC <= 8'h00;
        w(3);
        // between edges on purpose: the chip reset must not wait for CLK
        #30 CHIP_RESET_N = 1'b0;
        #1 chk(IRQ_N_OE, 1'b0);
        @(posedge CLK) CHIP_RESET_N <= 1'b1;
        w(4);
    endtask : t_irq
    task finish_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        w(10);
        RESET <= 1'b0;
        w(4);
        t_map;
        t_latch;
        t_irq;
        finish_test;
    end
    // hang guard, well beyond the roughly 160 cycles used
    initial begin
        w(3000);
        err_count++;
        finish_test;
    end
endmodule : host_bus_register_port_tb
